// file: hw/tpm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"

// Contract
// - Pulse mode counts from trigger edge on ticks.
// - Start field picks edge; option bit picks capture.
// - Single edge: opposite edge captures, interrupts, loads one.
// - Double edge: capture both edges, clear on trigger.
// - Single edge: counter holds at one after capture.
// - Output mode: edge or command start, shot select.
// - Continuous: duty and period matches toggle, interrupt.
// - Stopping by software keeps output level.
// - One shot: period match clears start, stops.
// - Output pin is inverse of flip-flop.
// - Reset clears the output flip-flop.
// - Inverted stop: init write loads inverted value.

module tpm_top #(
    parameter int DIV_SLOW = `TPM_DIV_SLOW,
    parameter int DIV_FAST = `TPM_DIV_FAST
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire tpm_pkg::tpm_addr_t PADDR_I,
    input wire tpm_pkg::tpm_data_t PWDATA_I,
    output var tpm_pkg::tpm_data_t PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Timer pins
    input wire logic TIMER_IN_I,
    output logic PULSE_OUT_O,
    output logic TIMER_IRQ_O
);

    import tpm_pkg::*;

    tpm_ctrl_t ctrl;
    tpm_cnt_t period;
    tpm_cnt_t duty;
    tpm_cnt_t count;
    tpm_cnt_t next_count;
    tpm_state_t state;
    tpm_state_t next_state;
    logic ff;
    logic next_ff;
    logic start_level;
    logic in_prev;
    logic tick;
    logic cap_load;
    logic next_irq;
    logic clr_start;
    logic ff_toggle;

    // Control field decode.
    wire [`TPM_MODE_MSB:`TPM_MODE_LSB] mode =
        ctrl[`TPM_MODE_MSB:`TPM_MODE_LSB];
    wire [`TPM_START_MSB:`TPM_START_LSB] start =
        ctrl[`TPM_START_MSB:`TPM_START_LSB];
    wire opt = ctrl[`TPM_OPT_BIT];
    wire is_pulse = (mode == `TPM_MODE_PULSE);
    wire is_ppg = (mode == `TPM_MODE_PPG);
    wire active = is_pulse || is_ppg;
    wire stopped = (start == `TPM_START_STOP);
    wire single = is_pulse && opt;
    wire shot = is_ppg && opt;

    // Pin edge detection; the pin is already synchronous to CLK_I.
    wire rise = TIMER_IN_I && !in_prev;
    wire fall = !TIMER_IN_I && in_prev;
    wire trig_edge = (start == `TPM_START_RISE) ? rise :
                     (start == `TPM_START_FALL) ? fall : 1'b0;
    wire opp_edge = (start == `TPM_START_RISE) ? fall :
                    (start == `TPM_START_FALL) ? rise : 1'b0;
    wire cmd_go = is_ppg && (start == `TPM_START_CMD);
    wire go = cmd_go || trig_edge;

    // Compare logic looks at the value the counter is about to take.
    wire running = (state == TPM_ST_RUN);
    wire [`TPM_CNT_W-1:0] cnt_inc = `TPM_CNT_W'(count + `TPM_CNT_ONE);
    wire dmatch = is_ppg && running && tick && (cnt_inc == duty);
    wire pmatch = is_ppg && running && tick && (cnt_inc == period);

    // APB decode.
    wire setup = PSEL_I && !PENABLE_I;
    wire access = PSEL_I && PENABLE_I && PREADY_O;
    wire sel_ctrl = (PADDR_I == `TPM_ADDR_CTRL);
    wire sel_period = (PADDR_I == `TPM_ADDR_PERIOD);
    wire sel_duty = (PADDR_I == `TPM_ADDR_DUTY);
    wire sel_status = (PADDR_I == `TPM_ADDR_STATUS);
    wire mapped = sel_ctrl || sel_period || sel_duty || sel_status;
    wire wr = access && PWRITE_I && mapped;
    wire ctrl_wr = wr && sel_ctrl;
    wire period_wr = wr && sel_period;
    // The duty register only accepts writes in pulse output mode.
    wire duty_wr = wr && sel_duty && is_ppg;

    wire [`TPM_MODE_MSB:`TPM_MODE_LSB] w_mode =
        PWDATA_I[`TPM_MODE_MSB:`TPM_MODE_LSB];
    wire w_tff = PWDATA_I[`TPM_TFF_BIT];
    wire w_enter_ppg = ctrl_wr && (w_mode == `TPM_MODE_PPG);
    // The init bit reaches the flip-flop only while the counter is idle,
    // so a careless write during a run cannot disturb the output.
    wire init_load = w_enter_ppg && !running;
    wire init_fresh = !is_ppg;
    wire init_inverted = (ff != start_level);
    // The level at each start is kept, since a later init write must
    // know whether the run left the output inverted.
    wire start_now = is_ppg && !running && (next_state == TPM_ST_RUN);

    wire tpm_data_t rd_ctrl = tpm_data_t'(ctrl);
    wire tpm_data_t rd_period = tpm_data_t'(period);
    wire tpm_data_t rd_duty = tpm_data_t'(duty);
    wire tpm_data_t rd_status = tpm_data_t'({ff, running, count});
    wire tpm_data_t rd_word = sel_ctrl ? rd_ctrl :
                              sel_period ? rd_period :
                              sel_duty ? rd_duty :
                              sel_status ? rd_status : tpm_data_t'(0);

    tpm_prescaler #(
        .DIV_A(DIV_SLOW),
        .DIV_B(DIV_FAST),
        .W(`TPM_PRE_W)
    ) u_prescaler (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .sel_i(ctrl[`TPM_CKSEL_BIT]),
        .tick_o(tick)
    );

    // Counter sequencing for both modes.
    always_comb begin
        next_state = state;
        next_count = count;
        cap_load = 1'b0;
        next_irq = 1'b0;
        clr_start = 1'b0;
        ff_toggle = 1'b0;
        if (!active || stopped) begin
            // Stop clears the counter but leaves the flip-flop alone.
            next_state = TPM_ST_WAIT;
            next_count = `TPM_CNT_ZERO;
        end else begin
            unique case (state)
                TPM_ST_WAIT: begin
                    if (go) begin
                        next_state = TPM_ST_RUN;
                    end
                end
                TPM_ST_RUN: begin
                    if (tick) begin
                        next_count = cnt_inc;
                    end
                    if (is_pulse) begin
                        if (opp_edge) begin
                            cap_load = 1'b1;
                            next_irq = 1'b1;
                            if (single) begin
                                next_count = `TPM_CNT_ONE;
                                next_state = TPM_ST_WAIT;
                            end
                        end else if (trig_edge && !single) begin
                            cap_load = 1'b1;
                            next_irq = 1'b1;
                            next_count = `TPM_CNT_ZERO;
                        end
                    end else begin
                        // Interrupt is raised from the match itself, so a
                        // clear in the same cycle cannot swallow it.
                        next_irq = dmatch || pmatch;
                        ff_toggle = dmatch ^ pmatch;
                        if (pmatch) begin
                            next_count = `TPM_CNT_ZERO;
                            if (shot) begin
                                clr_start = 1'b1;
                                next_state = TPM_ST_WAIT;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Output flip-flop. Entering output mode while idle loads the init bit as
    // written; a later write while stopped inverted loads its inverse.
    always_comb begin
        next_ff = ff;
        if (ff_toggle) begin
            next_ff = !ff;
        end else if (init_load) begin
            if (init_fresh) begin
                next_ff = w_tff;
            end else if (init_inverted) begin
                next_ff = !w_tff;
            end else begin
                next_ff = w_tff;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ctrl <= `TPM_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl <= PWDATA_I[`TPM_CTRL_W-1:0];
        end else if (clr_start) begin
            ctrl[`TPM_START_MSB:`TPM_START_LSB] <= `TPM_START_STOP;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            period <= `TPM_PERIOD_RST;
            duty <= `TPM_DUTY_RST;
        end else begin
            if (period_wr) begin
                period <= PWDATA_I[`TPM_CNT_W-1:0];
            end
            if (cap_load) begin
                duty <= count;
            end else if (duty_wr) begin
                duty <= PWDATA_I[`TPM_CNT_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            state <= TPM_ST_WAIT;
            count <= `TPM_CNT_ZERO;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Reset to low matches a pin idling low; a pin idling high would
    // show one false rise right after reset.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            in_prev <= 1'b0;
        end else begin
            in_prev <= TIMER_IN_I;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            ff <= 1'b0;
            start_level <= 1'b0;
        end else begin
            ff <= next_ff;
            if (start_now) begin
                start_level <= ff;
            end
        end
    end

    // The pulse pin follows the next flip-flop value, so both change at one edge.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            PULSE_OUT_O <= 1'b1;
            TIMER_IRQ_O <= 1'b0;
        end else begin
            PULSE_OUT_O <= !next_ff;
            TIMER_IRQ_O <= next_irq;
        end
    end

    // Decoding in the setup cycle lets every APB output come straight from a flop, with no wait state.
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            PRDATA_O <= tpm_data_t'(0);
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= setup;
            if (setup) begin
                PRDATA_O <= PWRITE_I ? tpm_data_t'(0) : rd_word;
                PSLVERR_O <= !mapped;
            end else begin
                PSLVERR_O <= 1'b0;
            end
        end
    end

endmodule // tpm_top

`default_nettype wire

// file: shared/tpm_defines.svh
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// Bus geometry.
`define TPM_ADDR_W 8
`define TPM_DATA_W 32

// Register byte addresses.
`define TPM_ADDR_CTRL 8'h00
`define TPM_ADDR_PERIOD 8'h04
`define TPM_ADDR_DUTY 8'h08
`define TPM_ADDR_STATUS 8'h0C

// Control register layout.
`define TPM_CTRL_W 8
`define TPM_MODE_LSB 0
`define TPM_MODE_MSB 2
`define TPM_CKSEL_BIT 3
`define TPM_START_LSB 4
`define TPM_START_MSB 5
`define TPM_OPT_BIT 6
`define TPM_TFF_BIT 7

// Mode field codes; every code but pulse and PPG, timer included, leaves this block stopped.
`define TPM_MODE_TIMER 3'h4
`define TPM_MODE_PULSE 3'h6
`define TPM_MODE_PPG 3'h7

// Start field codes.
`define TPM_START_STOP 2'h0
`define TPM_START_CMD 2'h1
`define TPM_START_RISE 2'h2
`define TPM_START_FALL 2'h3

// Counter and reset values.
`define TPM_CNT_W 16
`define TPM_CNT_ZERO 16'h0000
`define TPM_CNT_ONE 16'h0001
`define TPM_CTRL_RST 8'h00
`define TPM_PERIOD_RST 16'hFFFF
`define TPM_DUTY_RST 16'hFFFF

// Source clock divider defaults, in system clock cycles.
`define TPM_DIV_SLOW 128
`define TPM_DIV_FAST 8
`define TPM_PRE_W 16

`endif

// file: shared/tpm_pkg.sv
`default_nettype none
`include "tpm_defines.svh"

package tpm_pkg;

    typedef logic [`TPM_DATA_W-1:0] tpm_data_t;
    typedef logic [`TPM_ADDR_W-1:0] tpm_addr_t;
    typedef logic [`TPM_CNT_W-1:0] tpm_cnt_t;
    typedef logic [`TPM_CTRL_W-1:0] tpm_ctrl_t;

    typedef enum logic {
        TPM_ST_WAIT = 1'b0,
        TPM_ST_RUN = 1'b1
    } tpm_state_t;

endpackage

`default_nettype wire

// file: hw/tpm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"

module tpm_prescaler #(
    parameter int DIV_A = `TPM_DIV_SLOW,
    parameter int DIV_B = `TPM_DIV_FAST,
    parameter int W = `TPM_PRE_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Ratio select and tick out
    input wire logic sel_i,
    output logic tick_o
);

    logic [W-1:0] cnt;
    wire [W-1:0] last_a = W'(DIV_A - 1);
    wire [W-1:0] last_b = W'(DIV_B - 1);
    wire [W-1:0] last = sel_i ? last_b : last_a;
    // Compare with >= so a ratio change mid-period cannot overrun the count.
    wire wrap = (cnt >= last);
    wire [W-1:0] next_cnt = wrap ? {W{1'b0}} : W'(cnt + W'(1));

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt <= {W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= wrap;
        end
    end

endmodule // tpm_prescaler

`default_nettype wire

// file: test/tpm_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_chk (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic NRST_I,
    // Bus and pins
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire tpm_pkg::tpm_data_t PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic PULSE_OUT_O,
    input wire logic TIMER_IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence setup_s;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence access_s;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence
    ready_after_a: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    ready_once_a: assert property (access_s |=> !PREADY_O)
        else $error("ready held");
    ready_cause_a: assert property (PREADY_O |-> PSEL_I && $past(PSEL_I))
        else $error("ready without select");
    err_zero_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
        else $error("bad error answer");
    err_once_a: assert property (PSLVERR_O |=> !PSLVERR_O)
        else $error("error held");
    reset_idle_a: assert property (disable iff (1'b0)
        !NRST_I |=> PULSE_OUT_O && !TIMER_IRQ_O && !PREADY_O)
        else $error("reset state wrong");
    irq_pulse_a: assert property (TIMER_IRQ_O |=> !TIMER_IRQ_O)
        else $error("irq longer than a cycle");
    toggle_irq_a: assert property (
        $changed(PULSE_OUT_O) && !$past(PREADY_O) |-> TIMER_IRQ_O)
        else $error("toggle without irq");
endmodule // tpm_chk
bind tpm_top tpm_chk u_chk (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I),
    .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O),
    .PULSE_OUT_O(PULSE_OUT_O),
    .TIMER_IRQ_O(TIMER_IRQ_O)
);
`default_nettype wire

// file: test/tpm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpm_pin_model #(
    parameter int HI = 16,
    parameter int LO = 24
) (
    // Clock and enable
    input wire logic clk_i,
    input wire logic en_i,
    // Source pin
    output logic pin_o
);
    int cnt = 0;
    initial pin_o = 1'b0;
    // A low phase comes first, so the first edge after enable is a rise.
    always @(posedge clk_i) begin
        if (!en_i) begin
            cnt <= 0;
            pin_o <= 1'b0;
        end else begin
            cnt <= (cnt == HI + LO - 1) ? 0 : cnt + 1;
            pin_o <= (cnt >= LO);
        end
    end
endmodule // tpm_pin_model
`default_nettype wire

// file: test/tpm_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_top_test;
    import tpm_pkg::*;
    localparam int DIV = 4;
    localparam int DIVF = 2;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    tpm_addr_t paddr = 8'h00;
    tpm_data_t pwd = 32'h0;
    tpm_data_t prd, rd, a, b;
    logic prdy, perr, err, pin, pout, irq;
    logic src_en = 1'b0;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    int cyc = 0;
    int last = 0;
    tpm_top #(.DIV_SLOW(DIV), .DIV_FAST(DIVF)) dut (
        .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .TIMER_IN_I(pin),
        .PULSE_OUT_O(pout), .TIMER_IRQ_O(irq));
    tpm_pin_model #(.HI(16), .LO(24)) src (
        .clk_i(clk), .en_i(src_en), .pin_o(pin));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Free cycle count, so irq spacing is not skewed by bus calls.
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input tpm_data_t got, input tpm_data_t exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // The request is held until ready is seen at an edge, then released.
    task automatic apb(input logic wr, input tpm_addr_t ad, input int d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= ad;
        pwd <= 32'(d);
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (prdy !== 1'b1 && k < 50);
        if (k >= 50) num_errors++;
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wait_irq();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (irq !== 1'b1 && k < 300);
        if (k >= 300) num_errors++;
        n = cyc - last;
        last = cyc;
    endtask
    task automatic quiet(input logic lvl);
        int k;
        k = 0;
        repeat (60) @(posedge clk) if (irq === 1'b1) k++;
        chk(32'(k), 32'h0);
        chk({31'h0, pout}, {31'h0, lvl});
    endtask
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk({31'h0, pout}, 32'h1);
        apb(0, `TPM_ADDR_PERIOD, 0);
        chk(rd, 32'hFFFF);
        apb(0, 8'h10, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, `TPM_ADDR_CTRL, 'h0F);
        apb(1, `TPM_ADDR_PERIOD, 'hA);
        apb(1, `TPM_ADDR_DUTY, 'h4);
        apb(1, `TPM_ADDR_CTRL, 'h1F);
        wait_irq();
        chk({31'h0, pout}, 32'h0);
        wait_irq();
        chk(32'(n), 32'(6 * DIVF));
        chk({31'h0, pout}, 32'h1);
        wait_irq();
        chk(32'(n), 32'(4 * DIVF));
        apb(1, `TPM_ADDR_CTRL, 'h07);
        quiet(1'b0);
        apb(1, `TPM_ADDR_CTRL, 'h87);
        @(posedge clk);
        chk({31'h0, pout}, 32'h1);
        apb(1, `TPM_ADDR_CTRL, 'h04);
        apb(1, `TPM_ADDR_CTRL, 'h87);
        @(posedge clk);
        chk({31'h0, pout}, 32'h0);
        apb(1, `TPM_ADDR_CTRL, 'h04);
        apb(1, `TPM_ADDR_CTRL, 'h07);
        apb(1, `TPM_ADDR_CTRL, 'h67);
        src_en <= 1'b1;
        wait_irq();
        wait_irq();
        chk(32'(n), 32'(6 * DIV));
        apb(0, `TPM_ADDR_CTRL, 0);
        chk(rd, 32'h47);
        quiet(1'b1);
        src_en <= 1'b0;
        apb(1, `TPM_ADDR_CTRL, 'h46);
        apb(1, `TPM_ADDR_CTRL, 'h66);
        src_en <= 1'b1;
        wait_irq();
        apb(0, `TPM_ADDR_DUTY, 0);
        a = rd;
        wait_irq();
        chk(32'(n), 32'd40);
        apb(0, `TPM_ADDR_DUTY, 0);
        chk(rd, a + 32'h1);
        b = rd;
        wait_irq();
        apb(0, `TPM_ADDR_DUTY, 0);
        chk(rd, b);
        src_en <= 1'b0;
        apb(1, `TPM_ADDR_CTRL, 'h06);
        apb(1, `TPM_ADDR_CTRL, 'h36);
        src_en <= 1'b1;
        wait_irq();
        wait_irq();
        wait_irq();
        apb(0, `TPM_ADDR_DUTY, 0);
        a = rd;
        wait_irq();
        chk(32'(n), 32'd16);
        apb(0, `TPM_ADDR_DUTY, 0);
        chk(rd - a, 32'(16 / DIV));
        b = rd;
        wait_irq();
        wait_irq();
        apb(0, `TPM_ADDR_DUTY, 0);
        chk(rd, b);
        print_verdict();
    end
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule // tpm_top_test
`default_nettype wire
